// File: pkg/buf_regs_pkg.sv
// Constants, types and carriers for the status and impedance register slice
package buf_regs_pkg;
    // Register addresses
    localparam logic [7:0] CFG_ADDR = 8'h13;
    localparam logic [7:0] ZLOW_ADDR = 8'h14;
    localparam logic [7:0] ZHIGH_ADDR = 8'h15;
    // Config and status field positions
    localparam int CFG_RSVD_MSB = 7;
    localparam int CFG_RSVD_LSB = 5;
    localparam int CFG_EVER_BIT = 4;
    localparam int CFG_KEEP_BIT = 3;
    localparam int CFG_SDA_TO_BIT = 2;
    localparam int CFG_PRESENT_BIT = 0;
    // Reset values
    localparam logic [2:0] CFG_RSVD_RST = 3'h0;
    localparam logic CFG_KEEP_RST = 1'b1;
    localparam logic CFG_SDA_TO_RST = 1'b1;
    localparam logic [7:0] ZLOW_RST = 8'h00;
    localparam logic [7:0] ZHIGH_RST = 8'hFF;
    localparam logic [7:0] RD_RST = 8'h00;
    localparam int NUM_OUT = 8;
    // Timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TIMEOUT_US = 25_000;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int TO_W = 18;
    localparam logic [1:0] SETTLE_CYC = 2'h3;

    typedef enum logic [1:0] {
        Z_85 = 2'b00,
        Z_100 = 2'b01,
        Z_34 = 2'b10
    } zout_type;

    typedef enum logic [1:0] {
        STRAP_LOW = 2'b00,
        STRAP_MID = 2'b01,
        STRAP_HIGH = 2'b10
    } strap_type;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } boot_type;

    typedef struct packed {
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wr_data;
    } reg_req_type;
endpackage : buf_regs_pkg

// File: logic/pin_sync.sv
// Three-stage pin synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pin in, filtered level out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    q[i] <= s3_ff[i];
                end
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

// File: logic/buffer_status_and_impedance_regs.sv
// Config/status and output impedance registers with bus timeout monitors
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [R01] The clock-ever-seen flag starts at 0, sets on first clock detect, and stays set.
// [R02] On power-down pin low, config is kept if keep-config is 1, cleared if 0; it resets to 1.
// [R03] A high-low-high power-down pin cycle with keep-config at 0 restores it to 1.
// [R04] The data-line timeout monitor runs only while its enable bit is 1, which is its reset value.
// [R05] The clock-line timeout monitor always runs, and either monitor releases a hung bus.
// [R06] The input-clock-present bit shows the detector state live and resets to 0.
// [R07] A low strap at power-up clears both low and high impedance bits of every output.
// [R08] A mid strap at power-up clears each low bit and sets each high bit.
// [R09] A high strap at power-up sets each low bit and clears each high bit.
// [R10] With the high bit 0, the low bit picks 85 ohm when 0 and 100 ohm when 1.
// [R11] The low impedance register holds one read-write bit per output, bit n for output n, reset 0.
// [R12] With the high bit 1 the output drives 34 ohm regardless of the low bit.
// [R13] Writes to read-only status bits are ignored and they keep showing hardware state.
module buffer_status_and_impedance_regs #(
    parameter int unsigned TIMEOUT_CYCLES = buf_regs_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port from the bus protocol engine
    input wire buf_regs_pkg::reg_req_type reg_req,
    output logic [7:0] rd_data,
    // Device pins
    input wire logic power_good_down_pin,
    input wire logic input_clock_detect,
    input wire logic [1:0] impedance_strap_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    // Bus release pulses
    output logic scl_release,
    output logic sda_release,
    // Per-output drive impedance code, two bits per output
    output logic [2*buf_regs_pkg::NUM_OUT-1:0] out_impedance
);
    localparam logic [buf_regs_pkg::TO_W-1:0] TO_LIMIT =
        buf_regs_pkg::TO_W'(TIMEOUT_CYCLES);
    default clocking dflt_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic pd_q;
    logic det_q;
    logic [1:0] strap_q;
    logic [1:0] bus_q;
    logic pd_prev_ff;
    logic clear_pend_ff;
    logic ever_ff;
    logic keep_ff;
    logic sda_to_en_ff;
    logic [2:0] rsvd_ff;
    logic [7:0] zlow_ff;
    logic [7:0] zhigh_ff;
    logic [1:0] settle_ff;
    buf_regs_pkg::boot_type st_ff;
    logic [buf_regs_pkg::TO_W-1:0] to_cnt_ff [2];
    logic [1:0] release_ff;
    logic pd_fall;
    logic pd_rise;
    logic cfg_clear;
    logic wr_cfg;
    logic wr_zlow;
    logic wr_zhigh;
    logic [1:0] mon_en;
    logic [1:0] strap_z;

    // Strap level to {high, low} impedance bits
    function automatic logic [1:0] strap_bits(input logic [1:0] lvl);
        case (buf_regs_pkg::strap_type'(lvl))
            buf_regs_pkg::STRAP_LOW: strap_bits = 2'b00;
            buf_regs_pkg::STRAP_MID: strap_bits = 2'b10;
            buf_regs_pkg::STRAP_HIGH: strap_bits = 2'b01;
            default: strap_bits = 2'b10;
        endcase
    endfunction : strap_bits
    // High and low select bits to drive impedance
    function automatic buf_regs_pkg::zout_type zdec(input logic hi,
                                                    input logic lo);
        zdec = hi ? buf_regs_pkg::Z_34 :
               lo ? buf_regs_pkg::Z_100 : buf_regs_pkg::Z_85;
    endfunction : zdec
    pin_sync #(.W(1), .RST_VAL(1'b1)) u_pd_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(power_good_down_pin),
        .q(pd_q)
    );
    pin_sync #(.W(1), .RST_VAL(1'b0)) u_det_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(input_clock_detect),
        .q(det_q)
    );
    pin_sync #(.W(2), .RST_VAL(2'b00)) u_strap_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(impedance_strap_pin),
        .q(strap_q)
    );
    pin_sync #(.W(2), .RST_VAL(2'b11)) u_bus_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d({sda_in, scl_in}),
        .q(bus_q)
    );

    assign pd_fall = pd_prev_ff & ~pd_q;
    assign pd_rise = ~pd_prev_ff & pd_q;
    assign cfg_clear = pd_fall & ~keep_ff; // R02
    assign wr_cfg = reg_req.wr_en && reg_req.addr == buf_regs_pkg::CFG_ADDR;
    assign wr_zlow = reg_req.wr_en && reg_req.addr == buf_regs_pkg::ZLOW_ADDR;
    assign wr_zhigh = reg_req.wr_en && reg_req.addr == buf_regs_pkg::ZHIGH_ADDR;
    assign mon_en = {sda_to_en_ff, 1'b1}; // R04 R05
    assign strap_z = strap_bits(strap_q); // R07 R08 R09

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pd_prev_ff <= 1'b1;
        end else begin
            pd_prev_ff <= pd_q;
        end
    end

    // Power-up strap sampling once the pin filters settle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff <= buf_regs_pkg::ST_SETTLE;
            settle_ff <= 2'h0;
        end else begin
            case (st_ff)
                buf_regs_pkg::ST_SETTLE: begin
                    settle_ff <= settle_ff + 2'h1;
                    if (settle_ff == buf_regs_pkg::SETTLE_CYC) begin
                        st_ff <= buf_regs_pkg::ST_LOAD;
                    end
                end
                buf_regs_pkg::ST_LOAD: st_ff <= buf_regs_pkg::ST_RUN;
                buf_regs_pkg::ST_RUN: begin
                    if (pd_rise && clear_pend_ff) begin
                        st_ff <= buf_regs_pkg::ST_LOAD;
                    end
                end
                default: st_ff <= buf_regs_pkg::ST_SETTLE;
            endcase
        end
    end

    // Pending restore after a clearing power-down
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clear_pend_ff <= 1'b0;
        end else if (cfg_clear) begin
            clear_pend_ff <= 1'b1;
        end else if (pd_rise) begin
            clear_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            keep_ff <= buf_regs_pkg::CFG_KEEP_RST;
        end else if (pd_rise && clear_pend_ff) begin
            keep_ff <= 1'b1; // R03
        end else if (wr_cfg) begin
            keep_ff <= reg_req.wr_data[buf_regs_pkg::CFG_KEEP_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || cfg_clear) begin
            sda_to_en_ff <= buf_regs_pkg::CFG_SDA_TO_RST; // R02 R04
            rsvd_ff <= buf_regs_pkg::CFG_RSVD_RST;
        end else if (wr_cfg) begin
            sda_to_en_ff <= reg_req.wr_data[buf_regs_pkg::CFG_SDA_TO_BIT];
            rsvd_ff <= reg_req.wr_data[buf_regs_pkg::CFG_RSVD_MSB:
                                       buf_regs_pkg::CFG_RSVD_LSB];
        end
    end

    // Sticky acquire flag, only hardware sets it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ever_ff <= 1'b0;
        end else if (det_q) begin
            ever_ff <= 1'b1; // R01 R13
        end
    end

    // Impedance select bits
    generate
        for (genvar n = 0; n < buf_regs_pkg::NUM_OUT; n++) begin : g_out
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    zlow_ff[n] <= buf_regs_pkg::ZLOW_RST[n]; // R11
                    zhigh_ff[n] <= buf_regs_pkg::ZHIGH_RST[n];
                end else if (st_ff == buf_regs_pkg::ST_LOAD) begin
                    zlow_ff[n] <= strap_z[0]; // R07 R08 R09
                    zhigh_ff[n] <= strap_z[1];
                end else if (cfg_clear) begin
                    zlow_ff[n] <= buf_regs_pkg::ZLOW_RST[n]; // R02
                    zhigh_ff[n] <= buf_regs_pkg::ZHIGH_RST[n];
                end else if (wr_zlow) begin
                    zlow_ff[n] <= reg_req.wr_data[n]; // R11
                end else if (wr_zhigh) begin
                    zhigh_ff[n] <= reg_req.wr_data[n];
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    out_impedance[2*n +: 2] <= buf_regs_pkg::Z_85;
                end else begin
                    out_impedance[2*n +: 2] <=
                        zdec(zhigh_ff[n], zlow_ff[n]); // R10 R12
                end
            end
            zsel_34_a: assert property ( // R12
                zhigh_ff[n] |=> out_impedance[2*n +: 2] == 2'b10)
                else $error("high select did not give 34 ohm");
            zsel_low_a: assert property ( // R10
                !zhigh_ff[n] |=>
                out_impedance[2*n +: 2] == {1'b0, $past(zlow_ff[n])})
                else $error("low select did not pick 85 or 100 ohm");
        end
    endgenerate
    // Bus timeout monitors, index 0 clock line, index 1 data line
    generate
        for (genvar i = 0; i < 2; i++) begin : g_mon
            always_ff @(posedge clk) begin
                if (!rst_b || bus_q[i] || !mon_en[i]) begin
                    to_cnt_ff[i] <= '0;
                end else if (to_cnt_ff[i] != TO_LIMIT) begin
                    to_cnt_ff[i] <= to_cnt_ff[i] + 1'b1;
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    release_ff[i] <= 1'b0;
                end else begin
                    release_ff[i] <= mon_en[i] && !bus_q[i] &&
                        to_cnt_ff[i] == TO_LIMIT - 1'b1; // R05
                end
            end
        end
    endgenerate
    assign scl_release = release_ff[0];
    assign sda_release = release_ff[1];
    // Read data, one cycle after the address
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= buf_regs_pkg::RD_RST;
        end else begin
            case (reg_req.addr)
                buf_regs_pkg::CFG_ADDR:
                    rd_data <= {rsvd_ff, ever_ff, keep_ff, sda_to_en_ff,
                                1'b0, det_q}; // R06 R13
                buf_regs_pkg::ZLOW_ADDR: rd_data <= zlow_ff;
                buf_regs_pkg::ZHIGH_ADDR: rd_data <= zhigh_ff;
                default: rd_data <= buf_regs_pkg::RD_RST;
            endcase
        end
    end

    ever_sticky_a: assert property (ever_ff |=> ever_ff) // R01
        else $error("clock-ever-seen flag dropped");
    ever_follows_a: assert property (det_q && !ever_ff |=> ever_ff) // R01
        else $error("clock-ever-seen flag missed detection");
    cfg_clear_a: assert property ( // R02
        cfg_clear && st_ff == buf_regs_pkg::ST_RUN |=>
        zlow_ff == buf_regs_pkg::ZLOW_RST &&
        zhigh_ff == buf_regs_pkg::ZHIGH_RST && sda_to_en_ff)
        else $error("clearing power-down left configuration");
    keep_back_a: assert property (pd_rise && clear_pend_ff |=> keep_ff) // R03
        else $error("keep-config not restored after pin cycle");
    cfg_kept_a: assert property ( // R02
        pd_fall && keep_ff && !reg_req.wr_en && st_ff == buf_regs_pkg::ST_RUN
        |=> zlow_ff == $past(zlow_ff) && sda_to_en_ff == $past(sda_to_en_ff))
        else $error("config changed on power-down with keep set");
    sda_off_a: assert property ( // R04
        !sda_to_en_ff ##1 !sda_to_en_ff |-> !sda_release)
        else $error("data-line release while monitor disabled");
    scl_timeout_a: assert property ( // R05
        scl_release |-> $past(to_cnt_ff[0]) == TO_LIMIT - 1'b1)
        else $error("clock-line release at wrong count");
    present_live_a: assert property ( // R06
        reg_req.addr == buf_regs_pkg::CFG_ADDR |=> rd_data[0] == $past(det_q))
        else $error("present bit not live");
    strap_load_a: assert property ( // R07 R08 R09
        st_ff == buf_regs_pkg::ST_LOAD |=> zlow_ff == {8{$past(strap_z[0])}}
        && zhigh_ff == {8{$past(strap_z[1])}})
        else $error("strap load gave wrong impedance bits");
    ro_write_a: assert property ( // R13
        wr_cfg && !det_q |=> ever_ff == $past(ever_ff))
        else $error("write changed read-only flag");
endmodule : buffer_status_and_impedance_regs
`default_nettype wire

// File: test/smbus_host_model.sv
// Bus host model: drives the register port and the bus line levels
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model (
    // Clock
    input wire logic clk,
    // Register port towards the device
    output var buf_regs_pkg::reg_req_type reg_req,
    input wire logic [7:0] rd_data,
    // Bus lines, pulled up while released
    output var logic scl_in,
    output var logic sda_in
);
    initial begin
        reg_req = '0;
        scl_in = 1'b1;
        sda_in = 1'b1;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr_en: 1'b1, addr: a, wr_data: d};
        @(posedge clk);
        reg_req.wr_en <= 1'b0;
    endtask : write_reg

    // Data is taken once the addressed edge has updated it
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req.addr <= a;
        @(posedge clk);
        #1 d = rd_data;
    endtask : read_reg

    // Holds one line low, then releases both to the pull-up level
    task automatic hold_low(input logic data_line, input int n);
        @(posedge clk);
        if (data_line) sda_in <= 1'b0;
        else scl_in <= 1'b0;
        repeat (n) @(posedge clk);
        scl_in <= 1'b1;
        sda_in <= 1'b1;
    endtask : hold_low
endmodule : smbus_host_model
`default_nettype wire

// File: test/buffer_status_and_impedance_regs_bench.sv
// Self-checking bench for the status and impedance register slice
`timescale 1ns/1ns
`default_nettype none
module buffer_status_and_impedance_regs_bench;
    localparam logic [7:0] A_CFG = buf_regs_pkg::CFG_ADDR;
    localparam logic [7:0] A_LO = buf_regs_pkg::ZLOW_ADDR;
    localparam logic [7:0] A_HI = buf_regs_pkg::ZHIGH_ADDR;
    localparam int CYC_LIMIT = 3000;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
    } row_type;

    logic clk;
    logic rst_b;
    buf_regs_pkg::reg_req_type reg_req;
    logic [7:0] rd_data;
    logic power_good_down_pin;
    logic input_clock_detect;
    logic [1:0] impedance_strap_pin;
    logic scl_in;
    logic sda_in;
    logic scl_release;
    logic sda_release;
    logic [15:0] out_impedance;
    int bad_count = 0;
    int n_tests = 0;
    int cyc_count = 0;
    int scl_rel_n = 0;
    int sda_rel_n = 0;
    row_type rows [6] = '{
        '{A_LO, 8'hA5, 8'hA5}, '{A_HI, 8'h0F, 8'h0F},
        '{A_CFG, 8'hFF, 8'hEC}, '{8'h20, 8'hFF, 8'h00},
        '{A_CFG, 8'h0C, 8'h0C}, '{A_LO, 8'h5A, 8'h5A}};

    buffer_status_and_impedance_regs #(.TIMEOUT_CYCLES(20)) i_dut (
        .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .rd_data(rd_data),
        .power_good_down_pin(power_good_down_pin),
        .input_clock_detect(input_clock_detect),
        .impedance_strap_pin(impedance_strap_pin),
        .scl_in(scl_in), .sda_in(sda_in), .scl_release(scl_release),
        .sda_release(sda_release), .out_impedance(out_impedance));

    smbus_host_model i_host (
        .clk(clk), .reg_req(reg_req), .rd_data(rd_data),
        .scl_in(scl_in), .sda_in(sda_in));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop();
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.read_reg(a, d);
        chk({8'h00, d}, {8'h00, e});
    endtask : rdchk

    task automatic set_pins(input logic pd, input logic det,
                            input logic [1:0] st, input int settle);
        @(posedge clk);
        power_good_down_pin <= pd;
        input_clock_detect <= det;
        impedance_strap_pin <= st;
        repeat (settle) @(posedge clk);
    endtask : set_pins

    // Per output: 34 ohm when the high bit is set, else low bit picks 85/100
    function automatic logic [15:0] zcode(input logic [7:0] lo,
                                          input logic [7:0] hi);
        logic [15:0] r;
        for (int n = 0; n < 8; n++) begin
            r[2*n +: 2] = hi[n] ? 2'h2 : {1'b0, lo[n]};
        end
        return r;
    endfunction : zcode

    always @(posedge clk) begin
        if (rst_b && scl_release === 1'b1) scl_rel_n++;
        if (rst_b && sda_release === 1'b1) sda_rel_n++;
    end

    always @(posedge clk) begin
        cyc_count++;
        if (cyc_count == CYC_LIMIT) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        rst_b = 1'b0;
        power_good_down_pin = 1'b1;
        input_clock_detect = 1'b0;
        impedance_strap_pin = 2'h0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
        rdchk(A_CFG, 8'h0C);
        rdchk(A_LO, 8'h00);
        rdchk(A_HI, 8'h00);
        chk(out_impedance, 16'h0000);
        foreach (rows[i]) begin
            i_host.write_reg(rows[i].addr, rows[i].data);
            rdchk(rows[i].addr, rows[i].exp);
        end
        chk(out_impedance, zcode(8'h5A, 8'h0F));
        // Live detector bit and sticky seen flag
        set_pins(1'b1, 1'b1, 2'h0, 8);
        rdchk(A_CFG, 8'h1D);
        set_pins(1'b1, 1'b0, 2'h0, 8);
        rdchk(A_CFG, 8'h1C);
        i_host.write_reg(A_CFG, 8'h0D);
        rdchk(A_CFG, 8'h1C);
        // Hung lines: one release each, data monitor gated by its enable
        i_host.hold_low(1'b0, 40);
        i_host.hold_low(1'b1, 40);
        repeat (8) @(posedge clk);
        chk(16'(scl_rel_n), 16'h0001);
        chk(16'(sda_rel_n), 16'h0001);
        i_host.write_reg(A_CFG, 8'h08);
        i_host.hold_low(1'b1, 40);
        i_host.hold_low(1'b0, 40);
        repeat (8) @(posedge clk);
        chk(16'(sda_rel_n), 16'h0001);
        chk(16'(scl_rel_n), 16'h0002);
        // Power-down with configuration kept
        set_pins(1'b0, 1'b0, 2'h2, 10);
        rdchk(A_LO, 8'h5A);
        set_pins(1'b1, 1'b0, 2'h2, 10);
        rdchk(A_LO, 8'h5A);
        rdchk(A_CFG, 8'h18);
        // Power-down with configuration cleared, strap high
        i_host.write_reg(A_CFG, 8'h00);
        set_pins(1'b0, 1'b0, 2'h2, 10);
        rdchk(A_LO, 8'h00);
        rdchk(A_HI, 8'hFF);
        rdchk(A_CFG, 8'h14);
        set_pins(1'b1, 1'b0, 2'h2, 10);
        rdchk(A_CFG, 8'h1C);
        rdchk(A_LO, 8'hFF);
        rdchk(A_HI, 8'h00);
        chk(out_impedance, 16'h5555);
        // Strap mid after a clearing cycle; low bits then ignored
        i_host.write_reg(A_CFG, 8'h04);
        set_pins(1'b0, 1'b0, 2'h1, 10);
        set_pins(1'b1, 1'b0, 2'h1, 10);
        rdchk(A_LO, 8'h00);
        rdchk(A_HI, 8'hFF);
        i_host.write_reg(A_LO, 8'hFF);
        repeat (3) @(posedge clk);
        #1 chk(out_impedance, 16'hAAAA);
        // Second reset starts a fresh power cycle
        @(posedge clk);
        rst_b <= 1'b0;
        impedance_strap_pin <= 2'h3;
        repeat (3) @(posedge clk);
        #1 chk(out_impedance, 16'h0000);
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
        rdchk(A_CFG, 8'h0C);
        rdchk(A_HI, 8'hFF);
        rdchk(A_LO, 8'h00);
        report_and_stop();
    end
endmodule : buffer_status_and_impedance_regs_bench
`default_nettype wire
